// ---- pkg/async_uart_receiver_regs.svh ----
/*
  register map, field positions, reset values and bit timing of the receiver.
  assumes inclusion by name from the design file and the bench.
*/
`ifndef ASYNC_UART_RECEIVER_REGS_SVH
`define ASYNC_UART_RECEIVER_REGS_SVH

// ==========================================================
// byte offsets on the register bus
`define RX_STATUS_CONTROL_OFS   8'h00
`define TX_STATUS_CONTROL_OFS   8'h04
`define RX_DATA_OFS             8'h08
`define IRQ_CONTROL_OFS         8'h0C

// ==========================================================
// receive_status_control fields
`define PORT_EN_BIT             7
`define NINE_BIT                6
`define RX_EN_BIT               4
`define FRAME_ERR_BIT           2
`define OVERRUN_BIT             1
`define NINTH_BIT               0
// transmit_status_control field
`define SYNC_BIT                4
// irq control fields
`define RX_IRQ_EN_BIT           0
`define PERIPH_IRQ_EN_BIT       1
`define GLOBAL_IRQ_EN_BIT       2
`define RPF_BIT                 3

// ==========================================================
// reset values
`define RX_STATUS_RESET         8'h00
`define TX_STATUS_RESET         8'h00
`define IRQ_CONTROL_RESET       8'h00

// ==========================================================
// bit timing in oversample ticks
`define TICKS_PER_BIT           16
`define START_CENTRE_TICK       4'h7
`define BIT_LAST_TICK           4'hF
`define MAJ_FIRST_TICK          4'hD
`define MAJ_SECOND_TICK         4'hE

// ==========================================================
// bus answers
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

// ---- pkg/async_uart_receiver_pkg.sv ----
/*
  types of the asynchronous receiver.
  assumes the constants header sits beside it.
*/
package async_uart_receiver_pkg;
  // ==========================================================
  // receiver sequence
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_type;
endpackage : async_uart_receiver_pkg

// ---- design/async_uart_receiver.sv ----
/*
  asynchronous serial receiver with two-entry fifo behind an axi4-lite slave.
  assumes an external baud generator giving a one-cycle tick at sixteen
  times the baud rate on aclk, and a receive pin from outside the domain.
*/
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
// Function
// - receive only while receive enable, port enable set and synchronous select clear
// - oversample line sixteen times per bit, shift register advances once per bit
// - finished character moves at once into a two-entry fifo
// - falling edge starts; half bit later line must be low, else quietly abandon
// - after valid start, one bit time to each centre, majority value shifted in
// - stop position sampled one bit after last data; low marks framing error
// - after stop bit character enters fifo and pending flag rises
// - reading receive data returns oldest character and removes it
// - pending flag high while enabled with unread character; writes cannot change it
// - interrupt request needs pending flag and all three enables set
// - each entry keeps its framing status; visible bit follows oldest entry
// - framing error neither stops reception nor raises an interrupt
// - port enable clear resets port and framing status; receive enable clear does not
// - third character on full fifo sets overrun and blocks new characters
// - overrun cleared only by clearing receive enable or port enable
// - nine-bit option shifts nine bits; ninth bit shows oldest character msb
// - characters travel least significant bit first and assemble that way
`timescale 1ns/1ns
`include "async_uart_receiver_regs.svh"

module async_uart_receiver
  import async_uart_receiver_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        oversample_tick,
  input  wire logic        receive_line_pin,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             receive_pending_flag,
  output logic             irq_request
);

  // ==========================================================
  // state
  typedef struct packed {
    rx_state_type    state;
    logic [3:0]      tick_cnt;
    logic [3:0]      bit_cnt;
    logic [8:0]      shift;
    logic [1:0]      samp;
    logic [1:0][8:0] fifo_data;
    logic [1:0]      fifo_framing_error_flag;
    logic [1:0]      fifo_cnt;
    logic            rd_ptr;
    logic            overrun_error_flag;
    logic            serial_port_enable;
    logic            nine;
    logic            continuous_receive_enable;
    logic            sync_sel;
    logic            receive_irq_enable;
    logic            peripheral_irq_enable;
    logic            global_irq_enable;
    logic            aw_got;
    logic            w_got;
    logic [7:0]      awaddr;
    logic [7:0]      wbyte;
    logic            wlane;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic            sync1;
    logic            sync2;
    logic            line_prev;
  } state_type;

  state_type q_reg;
  state_type q_next;

  logic       rx_on;
  logic       line;
  logic       maj;
  logic       push;
  logic       pop;
  logic       full;
  logic [8:0] push_word;
  logic       push_framing_error_flag;
  logic       wr_idx;
  logic [7:0] status_byte;

  // ==========================================================
  // combinational views
  assign rx_on  = q_reg.serial_port_enable & q_reg.continuous_receive_enable & ~q_reg.sync_sel;
  assign line   = q_reg.sync2;
  // two of three: two early samples and the centre sample
  assign maj    = (q_reg.samp[0] & q_reg.samp[1]) | (q_reg.samp[0] & line)
                | (q_reg.samp[1] & line);
  assign full   = (q_reg.fifo_cnt == 2'h2) & ~pop;
  assign wr_idx = q_reg.rd_ptr ^ q_reg.fifo_cnt[0];
  assign status_byte = {q_reg.serial_port_enable, q_reg.nine, 1'b0, q_reg.continuous_receive_enable, 1'b0,
                        (q_reg.fifo_cnt != 2'h0) & q_reg.fifo_framing_error_flag[q_reg.rd_ptr],
                        q_reg.overrun_error_flag,
                        (q_reg.fifo_cnt != 2'h0) & q_reg.fifo_data[q_reg.rd_ptr][8]};

  // pending flag is pure state, so no write path can touch it
  assign receive_pending_flag = rx_on & (q_reg.fifo_cnt != 2'h0);
  // framing status is not a term here
  assign irq_request = receive_pending_flag & q_reg.receive_irq_enable & q_reg.peripheral_irq_enable & q_reg.global_irq_enable;

  assign s_axi_awready = ~q_reg.aw_got & ~q_reg.bvalid;
  assign s_axi_wready  = ~q_reg.w_got & ~q_reg.bvalid;
  assign s_axi_bvalid  = q_reg.bvalid;
  assign s_axi_bresp   = q_reg.bresp;
  assign s_axi_arready = ~q_reg.rvalid;
  assign s_axi_rvalid  = q_reg.rvalid;
  assign s_axi_rdata   = q_reg.rdata;
  assign s_axi_rresp   = q_reg.rresp;

  // ==========================================================
  // next state
  always_comb begin
    q_next    = q_reg;
    push      = 1'b0;
    pop       = 1'b0;
    push_word = 9'h000;
    push_framing_error_flag = 1'b0;
    // two-stage synchroniser on the pin
    q_next.sync1 = receive_line_pin;
    q_next.sync2 = q_reg.sync1;
    if (oversample_tick) begin
      q_next.line_prev = line;
    end

    // receive sequencer, moved by the oversample tick; forced to idle in any cycle while reception is off
    case (q_reg.state)
      RX_IDLE: begin
        if (oversample_tick && rx_on && q_reg.line_prev && !line) begin
          q_next.state    = RX_START;
          q_next.tick_cnt = 4'h0;
        end
      end
      RX_START: begin
        if (oversample_tick) begin
          q_next.tick_cnt = q_reg.tick_cnt + 4'h1;
          if (q_reg.tick_cnt == `START_CENTRE_TICK) begin
            // glitch filter: a high centre drops back to edge search
            q_next.state    = line ? RX_IDLE : RX_DATA;
            q_next.tick_cnt = 4'h0;
            q_next.bit_cnt  = 4'h0;
          end
        end
      end
      RX_DATA, RX_STOP: begin
        if (oversample_tick) begin
          // sixteen ticks from one centre to the next
          q_next.tick_cnt = q_reg.tick_cnt + 4'h1;
          if (q_reg.tick_cnt == `MAJ_FIRST_TICK) begin
            q_next.samp[0] = line;
          end
          if (q_reg.tick_cnt == `MAJ_SECOND_TICK) begin
            q_next.samp[1] = line;
          end
          if (q_reg.tick_cnt == `BIT_LAST_TICK && q_reg.state == RX_DATA) begin
            q_next.shift   = {maj, q_reg.shift[8:1]};  // lsb first
            q_next.bit_cnt = q_reg.bit_cnt + 4'h1;
            if (q_reg.bit_cnt == (q_reg.nine ? 4'h8 : 4'h7)) begin
              q_next.state = RX_STOP;
            end
          end
          if (q_reg.tick_cnt == `BIT_LAST_TICK && q_reg.state == RX_STOP) begin
            // low stop level marks this character only
            push      = 1'b1;
            push_framing_error_flag = ~maj;
            push_word = q_reg.nine ? q_reg.shift : {1'b0, q_reg.shift[8:1]};
            // no wait for a stop gap: reception goes on
            q_next.state = RX_IDLE;
          end
        end
      end
      default: begin
        q_next.state = RX_IDLE;
      end
    endcase
    if (!rx_on) begin
      q_next.state = RX_IDLE;
    end

    // axi4-lite write: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      q_next.aw_got = 1'b1;
      q_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      q_next.w_got = 1'b1;
      q_next.wbyte = s_axi_wdata[7:0];
      q_next.wlane = s_axi_wstrb[0];
    end
    if (q_reg.aw_got && q_reg.w_got) begin
      q_next.aw_got = 1'b0;
      q_next.w_got  = 1'b0;
      q_next.bvalid = 1'b1;
      q_next.bresp  = `RESP_OKAY;
      case (q_reg.awaddr)
        `RX_STATUS_CONTROL_OFS: begin
          // status bits are read only, so pending and error flags stay put
          if (q_reg.wlane) begin
            q_next.serial_port_enable = q_reg.wbyte[`PORT_EN_BIT];
            q_next.nine = q_reg.wbyte[`NINE_BIT];
            q_next.continuous_receive_enable = q_reg.wbyte[`RX_EN_BIT];
          end
        end
        `TX_STATUS_CONTROL_OFS: begin
          if (q_reg.wlane) begin
            q_next.sync_sel = q_reg.wbyte[`SYNC_BIT];
          end
        end
        `IRQ_CONTROL_OFS: begin
          if (q_reg.wlane) begin
            q_next.receive_irq_enable = q_reg.wbyte[`RX_IRQ_EN_BIT];
            q_next.peripheral_irq_enable = q_reg.wbyte[`PERIPH_IRQ_EN_BIT];
            q_next.global_irq_enable  = q_reg.wbyte[`GLOBAL_IRQ_EN_BIT];
          end
        end
        `RX_DATA_OFS: begin
        end
        default: begin
          q_next.bresp = `RESP_SLVERR;
        end
      endcase
    end
    if (q_reg.bvalid && s_axi_bready) begin
      q_next.bvalid = 1'b0;
    end

    // axi4-lite read, answered one cycle after the address
    if (s_axi_arvalid && s_axi_arready) begin
      q_next.rvalid = 1'b1;
      q_next.rresp  = `RESP_OKAY;
      q_next.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        `RX_STATUS_CONTROL_OFS: begin
          q_next.rdata[7:0] = status_byte;
        end
        `TX_STATUS_CONTROL_OFS: begin
          q_next.rdata[`SYNC_BIT] = q_reg.sync_sel;
        end
        `IRQ_CONTROL_OFS: begin
          q_next.rdata[3:0] = {receive_pending_flag, q_reg.global_irq_enable, q_reg.peripheral_irq_enable, q_reg.receive_irq_enable};
        end
        `RX_DATA_OFS: begin
          // oldest character out, fifo advances
          q_next.rdata[7:0] = q_reg.fifo_data[q_reg.rd_ptr][7:0];
          pop = (q_reg.fifo_cnt != 2'h0);
        end
        default: begin
          q_next.rresp = `RESP_SLVERR;
        end
      endcase
    end
    if (q_reg.rvalid && s_axi_rready) begin
      q_next.rvalid = 1'b0;
    end

    // fifo update; a character landing on a full fifo is an overrun
    if (pop) begin
      q_next.rd_ptr = ~q_reg.rd_ptr;
    end
    if (push && rx_on && !q_reg.overrun_error_flag && full) begin
      q_next.overrun_error_flag = 1'b1;
    end
    if (push && rx_on && !q_reg.overrun_error_flag && !full) begin
      // stored at once with its own framing status
      q_next.fifo_data[wr_idx] = push_word;
      q_next.fifo_framing_error_flag[wr_idx] = push_framing_error_flag;
    end
    q_next.fifo_cnt = q_reg.fifo_cnt
                    + {1'b0, push && rx_on && !q_reg.overrun_error_flag && !full}
                    - {1'b0, pop};
    // only disable clears overrun; the set above cannot meet it in one cycle
    if (!q_reg.continuous_receive_enable || !q_reg.serial_port_enable) begin
      q_next.overrun_error_flag = 1'b0;
    end
    // port disable empties the fifo and clears its framing status; receive disable keeps the fifo
    if (!q_reg.serial_port_enable) begin
      q_next.fifo_cnt  = 2'h0;
      q_next.fifo_framing_error_flag = 2'h0;
      q_next.rd_ptr    = 1'b0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_reg           <= '0;
      q_reg.state     <= RX_IDLE;
      q_reg.serial_port_enable      <= 1'(`RX_STATUS_RESET >> `PORT_EN_BIT);
      q_reg.sync1     <= 1'b1;
      q_reg.sync2     <= 1'b1;
      q_reg.line_prev <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_enable_gate: assert property (!rx_on |=> q_reg.state == RX_IDLE)
    else $error("receiver active while disabled");
  a_start_abort: assert property (q_reg.state == RX_START && oversample_tick
      && q_reg.tick_cnt == `START_CENTRE_TICK && line && rx_on
      |=> q_reg.state == RX_IDLE && $stable(q_reg.fifo_cnt))
    else $error("false start not abandoned quietly");
  a_bit_advance: assert property (q_reg.state == RX_DATA && oversample_tick && rx_on
      && q_reg.tick_cnt == `BIT_LAST_TICK |=> q_reg.bit_cnt == $past(q_reg.bit_cnt) + 4'h1)
    else $error("bit counter did not advance at bit end");
  a_fifo_depth: assert property (q_reg.fifo_cnt <= 2'h2)
    else $error("fifo count beyond two");
  a_pop_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `RX_DATA_OFS
      && q_reg.fifo_cnt != 2'h0 && !push && q_reg.serial_port_enable
      |=> q_reg.fifo_cnt == $past(q_reg.fifo_cnt) - 2'h1)
    else $error("data read did not advance fifo");
  a_irq_gate: assert property (irq_request |-> receive_pending_flag && q_reg.receive_irq_enable
      && q_reg.peripheral_irq_enable && q_reg.global_irq_enable)
    else $error("interrupt without all enables");
  a_overrun_set: assert property (push && rx_on && !q_reg.overrun_error_flag && full
      |=> q_reg.overrun_error_flag && q_reg.fifo_cnt == 2'h2)
    else $error("overrun not flagged on full fifo");
  a_overrun_hold: assert property (q_reg.overrun_error_flag && q_reg.continuous_receive_enable && q_reg.serial_port_enable |=> q_reg.overrun_error_flag)
    else $error("overrun cleared without disable");
  a_port_reset: assert property (!q_reg.serial_port_enable |=> q_reg.fifo_cnt == 2'h0 && !q_reg.overrun_error_flag
      && !status_byte[`FRAME_ERR_BIT])
    else $error("port disable left state behind");
  a_write_answer: assert property (q_reg.aw_got && q_reg.w_got |=> s_axi_bvalid)
    else $error("write not answered");

  c_char_stored: cover property (push && rx_on && !full && !q_reg.overrun_error_flag);
  c_overrun: cover property ($rose(q_reg.overrun_error_flag));
  c_frame_err: cover property (push && push_framing_error_flag && rx_on);
  c_nine_bit: cover property (push && q_reg.nine && push_word[8]);

endmodule : async_uart_receiver

// ---- test/uart_line_driver.sv ----
/*
  behavioural remote transmitter that drives the receive line.
  assumes the bench makes the oversample tick on aclk; sixteen ticks per bit.
*/
`timescale 1ns/1ns

module uart_line_driver (
  input  wire logic aclk,
  input  wire logic oversample_tick,
  output logic      line
);
  // ==========
  // line level: mark while idle
  initial line = 1'h1;

  // hold a level for some ticks; changed just after a clock edge
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge aclk iff oversample_tick);
  endtask : hold

  // one character: low start, data lsb first, stop at the chosen level
  task automatic send(input logic [8:0] d, input int nbits, input logic stop_lvl);
    hold(1'h0, 16);
    for (int i = 0; i < nbits; i++) begin
      hold(d[i], 16);
    end
    hold(stop_lvl, 16);
    // a low stop leaves no falling edge for the next start, so add one mark bit
    if (!stop_lvl) begin
      hold(1'h1, 16);
    end
  endtask : send

  // low pulse that ends well before the start centre
  task automatic glitch();
    hold(1'h0, 4);
    hold(1'h1, 16);
  endtask : glitch
endmodule : uart_line_driver

// ---- test/tb_async_uart_receiver.sv ----
/*
  self-checking bench of the receiver: queue model, bus tasks, line driver.
  assumes the design, its package and header, and uart_line_driver.
*/
`timescale 1ns/1ns
`include "async_uart_receiver_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module tb_async_uart_receiver
  import async_uart_receiver_pkg::*;
;
  // ==========
  // signals; every design input has a value at time zero
  logic        aclk = 1'h0, aresetn = 1'h0, oversample_tick = 1'h0, line;
  logic [1:0]  tick_div = 2'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata, rd;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp, rr;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, pend_o, irq_o;
  int          n_errors = 0, samples_checked = 0;
  // model: fifo of {framing, ninth, data}, overrun, mirror of control bits
  logic [9:0]  model_q[$];
  logic        model_ovr = 1'h0, sync_sel = 1'h0;
  logic [7:0]  ctl = 8'h00;
  logic [2:0]  ie = 3'h0;

  // ==========
  // clock; oversample tick every third cycle keeps frames short
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    tick_div <= (tick_div == 2'h2) ? 2'h0 : tick_div + 2'h1;
    oversample_tick <= (tick_div == 2'h2);
  end

  async_uart_receiver i_dut (
    .aclk(aclk), .aresetn(aresetn), .oversample_tick(oversample_tick),
    .receive_line_pin(line),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .receive_pending_flag(pend_o), .irq_request(irq_o)
  );
  // the model only drives the pin; the receiver passes it through a two-stage synchroniser
  uart_line_driver i_tx (.aclk(aclk), .oversample_tick(oversample_tick), .line(line));

  // ==========
  // bus tasks; each halves released only at the edge that takes it
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st,
                           input logic [1:0] er);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= st;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        wd = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'h0;
    `CHK("bresp", er, bresp)
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rr = rresp;
    rready <= 1'h0;
  endtask : bus_read

  // ==========
  // model checks; unless fe_known is set, the framing bit is masked while the model fifo is empty
  task automatic check_regs(input logic fe_known);
    logic [9:0] h;
    logic [7:0] msk;
    logic       pend;
    h = model_q.size() ? model_q[0] : 10'h000;
    msk = (fe_known || model_q.size()) ? 8'hFF : 8'hFB;
    pend = ctl[7] && ctl[4] && !sync_sel && model_q.size() > 0;
    bus_read(`RX_STATUS_CONTROL_OFS);
    `CHK("status", {24'h000000, {ctl[7:6], 1'h0, ctl[4], 1'h0, h[9], model_ovr, h[8]} & msk}, rd & {24'h000000, msk})
    bus_read(`IRQ_CONTROL_OFS);
    `CHK("irq_ctl", {28'h0000000, pend, ie}, rd)
    `CHK("pending", pend, pend_o)
    `CHK("irq", pend && ie == 3'h7, irq_o)
  endtask : check_regs

  // status first, so framing and ninth bit belong to the character popped next
  task automatic pop_check();
    check_regs(1'h1);
    bus_read(`RX_DATA_OFS);
    `CHK("rx_data", {24'h000000, model_q[0][7:0]}, rd)
    void'(model_q.pop_front());
  endtask : pop_check

  task automatic set_ctl(input logic [7:0] v);
    ctl = v & 8'hD0;
    bus_write(`RX_STATUS_CONTROL_OFS, v, 4'hF, `RESP_OKAY);
    if (!ctl[4] || !ctl[7]) model_ovr = 1'h0;
    if (!ctl[7]) model_q.delete();
  endtask : set_ctl

  // one random character; the model stores it only while reception is on
  task automatic rx_char(input logic fe);
    logic [8:0] v;
    v = 9'($urandom);
    if (!ctl[6]) v[8] = 1'h0;
    i_tx.send(v, ctl[6] ? 9 : 8, !fe);
    repeat (6) @(posedge aclk);
    if (ctl[7] && ctl[4] && !sync_sel) begin
      if (model_ovr || model_q.size() == 2) model_ovr = 1'h1;
      else model_q.push_back({fe, v});
    end
  endtask : rx_char

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // ==========
  // watchdog, well beyond the twenty or so frames of the run
  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    print_verdict();
  end

  // ==========
  // main sequence
  initial begin
    void'($urandom(43333));
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    check_regs(1'h1);
    bus_read(8'h10);
    `CHK("rresp", `RESP_SLVERR, rr)
    bus_write(8'h10, 8'hFF, 4'hF, `RESP_SLVERR);
    // synchronous select blocks reception
    bus_write(`TX_STATUS_CONTROL_OFS, 8'hFF, 4'hF, `RESP_OKAY);
    bus_read(`TX_STATUS_CONTROL_OFS);
    `CHK("tx_status", 32'h00000010, rd)
    sync_sel = 1'h1;
    set_ctl(8'h90);
    rx_char(1'h0);
    check_regs(1'h0);
    bus_write(`TX_STATUS_CONTROL_OFS, 8'h00, 4'hF, `RESP_OKAY);
    sync_sel = 1'h0;
    // read-only status bits ignore writes; a short low pulse is no start
    set_ctl(8'h97);
    i_tx.glitch();
    check_regs(1'h0);
    // every enable combination, pending bit not writable, zero strobe ignored
    rx_char(1'h0);
    for (int k = 0; k < 8; k++) begin
      ie = 3'(k);
      bus_write(`IRQ_CONTROL_OFS, {5'h01, ie}, 4'hF, `RESP_OKAY);
      check_regs(1'h0);
    end
    bus_write(`IRQ_CONTROL_OFS, 8'h00, 4'h0, `RESP_OKAY);
    pop_check();
    // framing patterns on two stored characters
    for (int p = 0; p < 4; p++) begin
      rx_char(p[0]);
      rx_char(p[1]);
      repeat (2) pop_check();
    end
    // overrun, blocked reception, clear by receive enable
    repeat (4) rx_char(1'h0);
    check_regs(1'h0);
    repeat (2) pop_check();
    rx_char(1'h0);
    check_regs(1'h0);
    set_ctl(8'h80);
    check_regs(1'h0);
    set_ctl(8'h90);
    // receive enable keeps framing status, port enable clears it
    rx_char(1'h1);
    set_ctl(8'h80);
    check_regs(1'h1);
    set_ctl(8'h90);
    check_regs(1'h1);
    set_ctl(8'h10);
    check_regs(1'h1);
    // nine-bit characters
    set_ctl(8'hD0);
    repeat (2) rx_char(1'($urandom));
    repeat (2) pop_check();
    print_verdict();
  end
endmodule : tb_async_uart_receiver
